/* File: core/cc_control_regs.sv */
// Purpose: c-channel decode into the line_control and test_diagnostic registers
// Assumes: framePulse one cycle wide, bitClock and serial input synchronous to clock
// Notes: registers are write-only from the serial side; their fields drive the
//        transceiver datapath through the outputs below
// Operation
// - select 0,0 writes line_control
// - select 1,0 writes test_diagnostic
// - inhibit clear: zero clears diagnostic at frame
// - bit 3 selects 80 or 160 kbit/s
// - d-channel byte carried in B1 slot
// - bit 5 enables both scramblers
// - bit 6 speeds echo canceller convergence
// - bits 4-7 all ones pick default
// - default one: control zero, diagnostics off
// - default two: rate bit only, diagnostics off
// - held control pin selects default mode
// - loop bits 0,0: no loopback
// - loop 0,1: system receive to transmit
// - loop 1,0: line output to input
// - loop 1,1: system transmit to receive
// - diagnostic bit 5 swaps scrambler polynomials
// - diagnostic bit 6 disables the line output
`timescale 1ns/10ps
`default_nettype none
module cc_control_regs import cc_pkg::*; (
    input wire logic clock,
    input wire logic nrst,
    input wire logic framePulse,
    input wire logic bitClock,
    input wire logic control_serial_in,
    input wire logic dualPortMode,
    output logic [7:0] lineControl,
    output logic [7:0] testDiagnostic,
    output logic diag_clear_inhibit,
    output logic line_rate_select,
    output logic d_in_b1_slot,
    output logic scrambler_enable,
    output logic convergence_speedup,
    output logic tx_housekeeping_bit,
    output logic systemLoopback,
    output logic lineLoopback,
    output logic endToEndLoopback,
    output logic forced_test_function,
    output logic polynomial_exchange,
    output logic line_out_disable,
    output logic controlWritten
);
    cc_link_if link (); // byte and strap events from the helpers

    logic [7:0] ctl_r, ctl_nxt;   // line_control
    logic [7:0] diag_r, diag_nxt; // test_diagnostic
    logic sysLoop_r, sysLoop_nxt; // decoded loopback paths
    logic lineLoop_r, lineLoop_nxt;
    logic e2eLoop_r, e2eLoop_nxt;
    logic ctlWr_r, ctlWr_nxt;     // pulse after any control-side update
    logic [1:0] selField;         // register select of the incoming byte
    logic isDefault;              // default-mode key present
    logic [1:0] loopNxt;          // loopback code about to be stored

    // byte assembly from the serial c-channel
    cc_serial_rx u_rx (
        .clock(clock),
        .nrst(nrst),
        .framePulse(framePulse),
        .bitClock(bitClock),
        .serialIn(control_serial_in),
        .link(link.rx)
    );

    // held-pin default detection, only active in dual-port use
    cc_pin_strap u_strap (
        .clock(clock),
        .nrst(nrst),
        .framePulse(framePulse),
        .dualPortMode(dualPortMode),
        .serialIn(control_serial_in),
        .link(link.strap)
    );

    assign selField = {link.byteData[SEL_HI_BIT], link.byteData[SEL_LO_BIT]};
    assign isDefault = ccIsDefault(link.byteData);

    // register update; later branches win, so a byte written in a cycle
    // beats the frame-pulse clear and a strap default
    always_comb begin
        ctl_nxt = ctl_r;
        diag_nxt = diag_r;
        ctlWr_nxt = 1'b0;
        // clearing is only kept off by a one in the inhibit bit
        if (framePulse && !ctl_r[CTL_CLR_INHIBIT_BIT]) begin
            diag_nxt = DIAG_CLEARED;
        end
        // a pin held all frame acts like the matching default byte
        if (link.strapValid) begin
            ctl_nxt = ccDefaultCtl(link.strapHigh);
            diag_nxt = DIAG_CLEARED;
            ctlWr_nxt = 1'b1;
        end
        if (link.byteValid) begin
            if (isDefault) begin
                // the key is checked ahead of the select bits, so it works
                // from either register and even from select 1,1
                ctl_nxt = ccDefaultCtl(link.byteData[CTL_RATE_BIT]);
                diag_nxt = DIAG_CLEARED;
                ctlWr_nxt = 1'b1;
            end else if (selField == SEL_CONTROL) begin
                ctl_nxt = link.byteData;
                ctlWr_nxt = 1'b1;
            end else if (selField == SEL_DIAG) begin
                diag_nxt = link.byteData;
            end
            // select 1,1 is unassigned and is dropped
        end
    end

    // loopback decode, kept in flops so the datapath sees clean levels
    assign loopNxt = ccLoopCode(diag_nxt);
    always_comb begin
        sysLoop_nxt = 1'b0;
        lineLoop_nxt = 1'b0;
        e2eLoop_nxt = 1'b0;
        unique case (loopNxt)
            LOOP_NONE: begin
                // normal operation, every path off
            end
            LOOP_SYSTEM: begin
                sysLoop_nxt = 1'b1;
            end
            LOOP_LINE: begin
                // the controller keeps this off as a framed follower
                lineLoop_nxt = 1'b1;
            end
            LOOP_END_TO_END: begin
                e2eLoop_nxt = 1'b1;
            end
        endcase
    end

    // registers only
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctl_r <= CTL_RESET;
            diag_r <= DIAG_RESET;
            sysLoop_r <= 1'b0;
            lineLoop_r <= 1'b0;
            e2eLoop_r <= 1'b0;
            ctlWr_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            diag_r <= diag_nxt;
            sysLoop_r <= sysLoop_nxt;
            lineLoop_r <= lineLoop_nxt;
            e2eLoop_r <= e2eLoop_nxt;
            ctlWr_r <= ctlWr_nxt;
        end
    end

    // field outputs are plain taps of the register flops
    assign lineControl = ctl_r;
    assign testDiagnostic = diag_r;
    assign diag_clear_inhibit = ctl_r[CTL_CLR_INHIBIT_BIT];
    assign line_rate_select = ctl_r[CTL_RATE_BIT];
    assign d_in_b1_slot = ctl_r[CTL_DINB1_BIT];
    assign scrambler_enable = ctl_r[CTL_SCRAM_BIT];
    assign convergence_speedup = ctl_r[CTL_SPEEDUP_BIT];
    assign tx_housekeeping_bit = ctl_r[CTL_HK_BIT];
    assign systemLoopback = sysLoop_r;
    assign lineLoopback = lineLoop_r;
    assign endToEndLoopback = e2eLoop_r;
    assign forced_test_function = diag_r[DIAG_FORCED_BIT];
    assign polynomial_exchange = diag_r[DIAG_POLY_BIT];
    assign line_out_disable = diag_r[DIAG_LINE_TX_OUTPUT_DIS_BIT];
    assign controlWritten = ctlWr_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // byte events used by the checks below
    sequence ctlByte;
        link.byteValid && !isDefault && selField == SEL_CONTROL;
    endsequence
    sequence diagByte;
        link.byteValid && !isDefault && selField == SEL_DIAG;
    endsequence
    sequence defaultByte;
        link.byteValid && isDefault;
    endsequence
    sequence quietCycle;
        !link.byteValid && !link.strapValid && !framePulse;
    endsequence

    control_write_a: assert property (
        ctlByte |=> lineControl == $past(link.byteData)
            && line_rate_select == $past(link.byteData[CTL_RATE_BIT]))
        else $error("control byte not stored");
    diag_write_a: assert property (
        diagByte |=> testDiagnostic == $past(link.byteData) && lineControl == $past(ctl_r))
        else $error("diagnostic byte not stored or control disturbed");
    frame_clear_a: assert property (
        framePulse && !diag_clear_inhibit && !link.byteValid && !link.strapValid
            |=> testDiagnostic == DIAG_CLEARED && !lineLoopback && !line_out_disable)
        else $error("diagnostic not cleared at frame pulse");
    clear_inhibit_a: assert property (
        framePulse && diag_clear_inhibit && !link.byteValid && !link.strapValid
            |=> $stable(testDiagnostic))
        else $error("diagnostic changed while clearing inhibited");
    default_mode_a: assert property (
        defaultByte |=> lineControl == ($past(link.byteData[CTL_RATE_BIT]) ?
            DEFAULT2_CTL : DEFAULT1_CTL) && testDiagnostic == DIAG_CLEARED
            && !systemLoopback && !lineLoopback && !endToEndLoopback)
        else $error("default key did not set default mode");
    strap_default_a: assert property (
        link.strapValid && !link.byteValid
            |=> lineControl == ($past(link.strapHigh) ? DEFAULT2_CTL : DEFAULT1_CTL))
        else $error("held pin did not select default mode");
    loop_decode_a: assert property (
        diagByte ##1 1'b1 |-> systemLoopback == (ccLoopCode(testDiagnostic) == LOOP_SYSTEM)
            && lineLoopback == (ccLoopCode(testDiagnostic) == LOOP_LINE)
            && endToEndLoopback == (ccLoopCode(testDiagnostic) == LOOP_END_TO_END))
        else $error("loopback paths disagree with diagnostic register");
    loop_exclusive_a: assert property (
        $onehot0({systemLoopback, lineLoopback, endToEndLoopback}))
        else $error("more than one loopback path active");
    control_hold_a: assert property (
        quietCycle |=> $stable(lineControl) && !controlWritten)
        else $error("control register changed without a write");
endmodule
`default_nettype wire

/* File: core/cc_pkg.sv */
// Purpose: shared constants, types and decode helpers of the c-channel register bank
// Assumes: one 100 MHz clock, control byte bit 0 arrives first on the serial input
// Notes: all field positions and reset values live here and nowhere else
`default_nettype none
package cc_pkg;
    // byte width of one c-channel
    localparam int CC_BYTE_W = 8;
    localparam logic [2:0] CC_LAST_BIT = 3'h7;
    // register select field, bit 0 and bit 1 of every byte
    localparam int SEL_LO_BIT = 0;
    localparam int SEL_HI_BIT = 1;
    localparam logic [1:0] SEL_CONTROL = 2'h0; // {bit1,bit0} = 0,0
    localparam logic [1:0] SEL_DIAG = 2'h2;    // {bit1,bit0} = 1,0
    // line_control fields
    localparam int CTL_CLR_INHIBIT_BIT = 2;
    localparam int CTL_RATE_BIT = 3;
    localparam int CTL_DINB1_BIT = 4;
    localparam int CTL_SCRAM_BIT = 5;
    localparam int CTL_SPEEDUP_BIT = 6;
    localparam int CTL_HK_BIT = 7;
    // test_diagnostic fields
    localparam int DIAG_LOOP_LO_BIT = 2;
    localparam int DIAG_LOOP_HI_BIT = 3;
    localparam int DIAG_FORCED_BIT = 4;
    localparam int DIAG_POLY_BIT = 5;
    localparam int DIAG_LINE_TX_OUTPUT_DIS_BIT = 6;
    // loopback codes as {bit2,bit3}
    localparam logic [1:0] LOOP_NONE = 2'h0;
    localparam logic [1:0] LOOP_SYSTEM = 2'h1;
    localparam logic [1:0] LOOP_LINE = 2'h2;
    localparam logic [1:0] LOOP_END_TO_END = 2'h3;
    // reset and default values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] DIAG_RESET = 8'h00;
    localparam logic [7:0] DIAG_CLEARED = 8'h00;
    localparam logic [7:0] DEFAULT1_CTL = 8'h00; // 80 kbit/s, all off
    localparam logic [7:0] DEFAULT2_CTL = 8'h08; // only the rate bit set
    localparam logic [3:0] DEFAULT_KEY = 4'hF;   // bits 4..7 all one
    // far-side convergence guidance, kept for reference by software
    localparam int SPEEDUP_FRAMES_160K = 240;
    localparam int SPEEDUP_FRAMES_80K = 480;

    // serial receiver states
    typedef enum logic [1:0] {CC_RX_WAIT, CC_RX_SHIFT, CC_RX_HOLD} cc_rx_state_t;

    // true when the byte carries the default-mode key
    function automatic logic ccIsDefault(input logic [7:0] b);
        return b[7:4] == DEFAULT_KEY;
    endfunction

    // control value for a default-mode byte or a strapped pin
    function automatic logic [7:0] ccDefaultCtl(input logic rateHigh);
        return rateHigh ? DEFAULT2_CTL : DEFAULT1_CTL;
    endfunction

    // loopback code of a diagnostic byte, bit 2 high-order
    function automatic logic [1:0] ccLoopCode(input logic [7:0] b);
        return {b[DIAG_LOOP_LO_BIT], b[DIAG_LOOP_HI_BIT]};
    endfunction
endpackage
`default_nettype wire

/* File: core/cc_link_if.sv */
// Purpose: carries received bytes and strap events from the helpers to the core
// Assumes: all signals in the single clock domain
// Notes: each helper drives its own group only
`timescale 1ns/10ps
`default_nettype none
interface cc_link_if;
    logic byteValid;  // one-cycle pulse, byte complete
    logic [7:0] byteData; // assembled c-channel byte
    logic strapValid; // one-cycle pulse in the cycle after a frame pulse, pin held all frame
    logic strapHigh;  // level of the held pin
    modport rx (output byteValid, output byteData);
    modport strap (output strapValid, output strapHigh);
    modport core (input byteValid, input byteData, input strapValid, input strapHigh);
endinterface
`default_nettype wire

/* File: core/cc_serial_rx.sv */
// Purpose: assembles the c-channel byte from the serial control input
// Assumes: bitClock and serialIn synchronous to clock, bit 0 first
// Notes: one byte per frame; later bits are ignored until the next frame pulse
`timescale 1ns/10ps
`default_nettype none
module cc_serial_rx import cc_pkg::*; (
    input wire logic clock,
    input wire logic nrst,
    input wire logic framePulse,
    input wire logic bitClock,
    input wire logic serialIn,
    cc_link_if.rx link
);
    cc_rx_state_t state_r, state_nxt; // receiver state
    logic [2:0] bitCnt_r, bitCnt_nxt; // next bit position
    logic [7:0] shift_r, shift_nxt;   // bits gathered so far
    logic bitClkPrev_r;               // last bit clock level, for edge finding
    logic valid_r, valid_nxt;         // byte complete pulse
    logic bitEdge;

    // a rising bit clock edge marks one data bit
    assign bitEdge = bitClock && !bitClkPrev_r;

    // next-state logic; a frame pulse always restarts the byte
    always_comb begin
        state_nxt = state_r;
        bitCnt_nxt = bitCnt_r;
        shift_nxt = shift_r;
        valid_nxt = 1'b0;
        if (framePulse) begin
            state_nxt = CC_RX_SHIFT;
            bitCnt_nxt = 3'h0;
        end else begin
            unique case (state_r)
                CC_RX_WAIT: begin
                    // idle until the first frame is seen
                end
                CC_RX_SHIFT: begin
                    if (bitEdge) begin
                        shift_nxt[bitCnt_r] = serialIn;
                        bitCnt_nxt = bitCnt_r + 3'h1;
                        if (bitCnt_r == CC_LAST_BIT) begin
                            valid_nxt = 1'b1;
                            state_nxt = CC_RX_HOLD;
                        end
                    end
                end
                CC_RX_HOLD: begin
                    // d-channel and other slots pass by untouched
                end
            endcase
        end
    end

    // registers only
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_r <= CC_RX_WAIT;
            bitCnt_r <= 3'h0;
            shift_r <= 8'h00;
            bitClkPrev_r <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bitCnt_r <= bitCnt_nxt;
            shift_r <= shift_nxt;
            bitClkPrev_r <= bitClock;
            valid_r <= valid_nxt;
        end
    end

    assign link.byteValid = valid_r;
    assign link.byteData = shift_r;

    // a completed byte is never reported twice in a row
    single_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        valid_r |=> !valid_r) else $error("byte valid lasted more than one cycle");
endmodule
`default_nettype wire

/* File: core/cc_pin_strap.sv */
// Purpose: spots a control input held at one level for a whole frame in dual-port use
// Assumes: frame pulses are one cycle wide
// Notes: the first frame after reset only arms the detector
`timescale 1ns/10ps
`default_nettype none
module cc_pin_strap import cc_pkg::*; (
    input wire logic clock,
    input wire logic nrst,
    input wire logic framePulse,
    input wire logic dualPortMode,
    input wire logic serialIn,
    cc_link_if.strap link
);
    logic armed_r, armed_nxt;     // a full frame has been watched
    logic allLow_r, allLow_nxt;   // pin low so far this frame
    logic allHigh_r, allHigh_nxt; // pin high so far this frame
    logic valid_r, valid_nxt;
    logic high_r, high_nxt;

    // a single opposite sample spoils the frame, so a live byte never looks strapped
    always_comb begin
        armed_nxt = armed_r;
        allLow_nxt = allLow_r && !serialIn;
        allHigh_nxt = allHigh_r && serialIn;
        valid_nxt = 1'b0;
        high_nxt = high_r;
        if (!dualPortMode) begin
            armed_nxt = 1'b0;
        end else if (framePulse) begin
            valid_nxt = armed_r && (allLow_r || allHigh_r);
            high_nxt = allHigh_r;
            armed_nxt = 1'b1;
            allLow_nxt = !serialIn;
            allHigh_nxt = serialIn;
        end
    end

    // registers only
    always_ff @(posedge clock) begin
        if (!nrst) begin
            armed_r <= 1'b0;
            allLow_r <= 1'b0;
            allHigh_r <= 1'b0;
            valid_r <= 1'b0;
            high_r <= 1'b0;
        end else begin
            armed_r <= armed_nxt;
            allLow_r <= allLow_nxt;
            allHigh_r <= allHigh_nxt;
            valid_r <= valid_nxt;
            high_r <= high_nxt;
        end
    end

    assign link.strapValid = valid_r;
    assign link.strapHigh = high_r;
endmodule
`default_nettype wire

/* File: testbench/cc_ctrl_model.sv */
// Purpose: system controller model that drives the serial c-channel side
// Assumes: block inputs change at the falling clock edge only
// Notes: between bits the data line toggles, so a stale bit never looks held
`timescale 1ns/10ps
`default_nettype none
module cc_ctrl_model (
    input wire logic clock,
    output logic framePulse,
    output logic bitClock,
    output logic serialIn
);
    logic holdLine = 1'b0; // strap use: data line parked at holdLevel
    logic holdLevel = 1'b0; // parked level of the data line
    // quiet lines at time zero
    initial begin
        framePulse = 1'b0;
        bitClock = 1'b0;
        serialIn = 1'b0;
    end
    // off-bit cycles show the inverse of the last value unless parked
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clock);
            framePulse <= 1'b0;
            bitClock <= 1'b0;
            serialIn <= holdLine ? holdLevel : ~serialIn;
        end
    endtask
    // one-cycle frame pulse; restarts the byte in the block
    task automatic frame();
        @(negedge clock);
        framePulse <= 1'b1;
        bitClock <= 1'b0;
        serialIn <= holdLine ? holdLevel : ~serialIn;
        idle(1);
    endtask
    // bit 0 first; lowLen low cycles give a clean rising edge for every bit
    task automatic send(input logic [7:0] b, input int nBits, input int lowLen);
        for (int k = 0; k < nBits; k++) begin
            idle(lowLen);
            @(negedge clock);
            bitClock <= 1'b1;
            serialIn <= b[k];
        end
    endtask
endmodule
`default_nettype wire

/* File: testbench/cchannel_control_diag_regs_tb.sv */
// Purpose: self-checking bench of the c-channel register bank
// Assumes: the controller model drives the serial side; checks land 3 clocks after events
// Notes: expectations come from a local decode of each byte, never from the outputs
`timescale 1ns/10ps
`default_nettype none
module cchannel_control_diag_regs_tb import cc_pkg::*; ;
    typedef struct packed {logic [7:0] ctl; logic [7:0] diag; int wr;} cc_exp_t; // one note
    logic clock;
    logic nrst = 1'b0; // held low from time zero
    logic dualPortMode = 1'b0; // strap detection off unless tested
    wire framePulse, bitClock, control_serial_in;
    logic [7:0] lineControl, testDiagnostic;
    logic diag_clear_inhibit, line_rate_select, d_in_b1_slot, scrambler_enable;
    logic convergence_speedup, tx_housekeeping_bit, systemLoopback, lineLoopback;
    logic endToEndLoopback, forced_test_function, polynomial_exchange, line_out_disable;
    logic controlWritten;
    logic [7:0] expCtl = CTL_RESET; // expected register contents
    logic [7:0] expDiag = DIAG_RESET;
    cc_exp_t expQ[$]; // notes waiting for the watcher
    event due; // a noted result is now settled at the ports
    int errCount = 0;
    int checkCount = 0;
    int expWr = 0; // control-side updates expected so far
    int wrSeen = 0; // control-side update pulses seen so far
    logic heldLevel = 1'b0; // level the open frame is parked at, what the next pulse judges

    cc_ctrl_model model (.clock, .framePulse, .bitClock, .serialIn(control_serial_in));
    cc_control_regs dut (.clock, .nrst, .framePulse, .bitClock, .control_serial_in,
        .dualPortMode, .lineControl, .testDiagnostic, .diag_clear_inhibit, .line_rate_select,
        .d_in_b1_slot, .scrambler_enable, .convergence_speedup, .tx_housekeeping_bit,
        .systemLoopback, .lineLoopback, .endToEndLoopback, .forced_test_function,
        .polynomial_exchange, .line_out_disable, .controlWritten);

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic checkReg(input string what, input logic [7:0] e, input logic [7:0] g);
        checkCount++;
        if (g !== e) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic checkBit(input string what, input logic e, input logic g);
        checkCount++;
        if (g !== e) begin
            errCount++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic checkNum(input string what, input int e, input int g);
        checkCount++;
        if (g != e) begin
            errCount++;
            $display("Error %s expected %0d seen %0d", what, e, g);
        end
    endtask
    // counts update pulses; an unknown pulse is not counted, so the pulse-count check in the watcher catches it
    always @(posedge clock) begin
        if (controlWritten === 1'b1) begin
            wrSeen <= wrSeen + 1;
        end
    end
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watcher: oldest note against every output once the result is due
    initial begin : watch
        cc_exp_t e;
        forever begin
            @(due);
            e = expQ.pop_front();
            checkReg("lineControl", e.ctl, lineControl);
            checkReg("testDiagnostic", e.diag, testDiagnostic);
            checkBit("diag_clear_inhibit", e.ctl[CTL_CLR_INHIBIT_BIT],
                diag_clear_inhibit);
            checkBit("line_rate_select", e.ctl[CTL_RATE_BIT], line_rate_select);
            checkBit("d_in_b1_slot", e.ctl[CTL_DINB1_BIT], d_in_b1_slot);
            checkBit("scrambler_enable", e.ctl[CTL_SCRAM_BIT], scrambler_enable);
            checkBit("convergence_speedup", e.ctl[CTL_SPEEDUP_BIT], convergence_speedup);
            checkBit("tx_housekeeping_bit", e.ctl[CTL_HK_BIT], tx_housekeeping_bit);
            checkBit("systemLoopback", e.diag[3:2] == 2'h2, systemLoopback);
            checkBit("lineLoopback", e.diag[3:2] == 2'h1, lineLoopback);
            checkBit("endToEndLoopback", e.diag[3:2] == 2'h3, endToEndLoopback);
            checkBit("forced_test_function", e.diag[DIAG_FORCED_BIT], forced_test_function);
            checkBit("polynomial_exchange", e.diag[DIAG_POLY_BIT], polynomial_exchange);
            checkBit("line_out_disable", e.diag[DIAG_LINE_TX_OUTPUT_DIS_BIT], line_out_disable);
            checkNum("controlWritten pulses", e.wr, wrSeen);
            checkBit("controlWritten", 1'b0, controlWritten);
        end
    end

    // a hang ends the run as a mismatch
    initial begin : watchdog
        repeat (100000) @(posedge clock);
        errCount++;
        $display("Error run length expected end seen hang");
        giveVerdict();
    end

    // note the expectation, let the 2-clock answer settle, then hand it over
    task automatic noteAndCheck();
        expQ.push_back({expCtl, expDiag, expWr});
        model.idle(3);
        -> due;
    endtask
    // frame pulse then one byte; partial bytes must leave the registers alone
    task automatic writeByte(input logic [7:0] b, input int nBits, input int lowLen);
        model.frame();
        if (!expCtl[CTL_CLR_INHIBIT_BIT]) expDiag = DIAG_CLEARED;
        model.send(b, nBits, lowLen);
        if (nBits == CC_BYTE_W) begin
            if (b[7:4] == DEFAULT_KEY) begin
                expCtl = b[CTL_RATE_BIT] ? DEFAULT2_CTL : DEFAULT1_CTL;
                expDiag = DIAG_CLEARED;
                expWr++;
            end else if (b[1:0] == SEL_CONTROL) begin
                expCtl = b;
                expWr++;
            end else if (b[1:0] == SEL_DIAG) begin
                expDiag = b;
            end
        end
        noteAndCheck();
    endtask
    // frame with no bits; strapped frames load the default of the parked level
    task automatic bareFrame(input logic strapped);
        model.frame();
        if (!expCtl[CTL_CLR_INHIBIT_BIT]) expDiag = DIAG_CLEARED;
        if (strapped) begin
            // the pulse judges the frame it closes, not the level parked from now on
            expCtl = heldLevel ? DEFAULT2_CTL : DEFAULT1_CTL;
            expDiag = DIAG_CLEARED;
            expWr++;
        end
        heldLevel = model.holdLevel;
        noteAndCheck();
        model.idle(8);
    endtask
    task automatic doReset(input int n);
        nrst <= 1'b0;
        model.idle(n);
        nrst <= 1'b1;
        expCtl = CTL_RESET;
        expDiag = DIAG_RESET;
        noteAndCheck();
    endtask
    // bit spacing varies so slow and prompt controllers are both seen
    task automatic runList(input string name, input logic [7:0] bytes[$]);
        foreach (bytes[i]) writeByte(bytes[i], CC_BYTE_W, 1 + i % 3);
        $display("test %s done", name);
    endtask

    initial begin : main
        logic [7:0] b;
        void'($urandom(32'h64a91c51));
        doReset(12);
        $display("test reset done");
        // power-up convergence: speedup held at 80 kbit/s, inhibit keeps diagnostics
        writeByte(8'h44, CC_BYTE_W, 1);
        repeat (SPEEDUP_FRAMES_80K) begin
            model.frame();
            model.idle(2);
        end
        // 160 kbit/s start-up needs only half the speedup window
        writeByte(8'h4C, CC_BYTE_W, 2);
        repeat (SPEEDUP_FRAMES_160K) begin
            model.frame();
            model.idle(2);
        end
        $display("test convergence done");
        runList("control fields", '{8'h04, 8'h0C, 8'h14, 8'h24, 8'h84});
        // line loopback is fair here, the model never acts as framed follower
        runList("diagnostic fields", '{8'h02, 8'h0A, 8'h06, 8'h0E, 8'h12, 8'h22, 8'h42, 8'h7E});
        // select 1,1 dropped; then inhibit off so the next pulses clear
        runList("refused and clear", '{8'h07, 8'h00, 8'h2A});
        bareFrame(1'b0);
        runList("rewrite each frame", '{8'h2A, 8'h2E});
        runList("default keys", '{8'h2C, 8'h5E, 8'hF4, 8'h2C, 8'h5E, 8'hFA});
        // frame pulse in mid-byte must drop the four bits already sent
        writeByte(8'hFF, 4, 1);
        runList("abort", '{8'h34, 8'h46});
        dualPortMode <= 1'b1;
        model.holdLine = 1'b1;
        model.holdLevel = 1'b0;
        bareFrame(1'b0);
        bareFrame(1'b1);
        model.holdLevel = 1'b1;
        // the frame closed here was still parked low, so it straps low once more
        bareFrame(1'b1);
        bareFrame(1'b1);
        dualPortMode <= 1'b0;
        model.holdLine = 1'b0;
        $display("test strap done");
        for (int i = 0; i < 24; i++) begin
            b = 8'($urandom);
            b[0] = 1'b0;
            if (b[1] && b[7:4] != DEFAULT_KEY) b[7] = 1'b0;
            writeByte(b, CC_BYTE_W, 1 + int'($urandom % 3));
        end
        $display("test random done");
        doReset(3);
        $display("test second reset done");
        model.idle(2);
        giveVerdict();
    end
endmodule
`default_nettype wire
